/* File: design/timer0_defs.svh */
// register offsets, field positions and encodings of the timer
`ifndef TIMER0_DEFS_SVH
`define TIMER0_DEFS_SVH

// register byte offsets on the bus
`define T0_OFS_COUNT    8'h00
`define T0_OFS_CMP_A    8'h04
`define T0_OFS_CMP_B    8'h08
`define T0_OFS_CTRL_A   8'h0C
`define T0_OFS_CTRL_B   8'h10
`define T0_OFS_FLAG     8'h14
`define T0_OFS_MASK     8'h18
`define T0_OFS_POWER    8'h1C

// count extremes
`define T0_BOTTOM       8'h00
`define T0_MAX          8'hFF
`define T0_ZERO8        8'h00
`define T0_ONE8         8'h01

// flag and mask bit positions
`define T0_BIT_OVF      0
`define T0_BIT_MATCH_A  1
`define T0_BIT_MATCH_B  2

// control field positions
`define T0_CA_WGM_LO    1:0
`define T0_CA_COM_B     5:4
`define T0_CA_COM_A     7:6
`define T0_CB_CS        2:0
`define T0_CB_WGM_HI    3
`define T0_CB_FOC_B     6
`define T0_CB_FOC_A     7
`define T0_CB_STORED    8'h0F

// tick source select encodings
`define T0_CS_STOP      3'h0
`define T0_CS_DIV1      3'h1
`define T0_CS_DIV8      3'h2
`define T0_CS_DIV64     3'h3
`define T0_CS_DIV256    3'h4
`define T0_CS_DIV1024   3'h5
`define T0_CS_EXT_FALL  3'h6
`define T0_CS_EXT_RISE  3'h7

// prescaler tap masks (divisor minus one)
`define T0_PS_M8        10'h007
`define T0_PS_M64       10'h03F
`define T0_PS_M256      10'h0FF
`define T0_PS_M1024     10'h3FF

// waveform mode encodings
`define T0_WGM_NORMAL   3'h0
`define T0_WGM_PC_MAX   3'h1
`define T0_WGM_CTC      3'h2
`define T0_WGM_FAST_MAX 3'h3
`define T0_WGM_PC_CMPA  3'h5
`define T0_WGM_FAST_CMPA 3'h7

// compare output actions
`define T0_COM_OFF      2'h0
`define T0_COM_TOGGLE   2'h1
`define T0_COM_CLEAR    2'h2
`define T0_COM_SET      2'h3

// bus responses
`define T0_RESP_OKAY    2'h0
`define T0_RESP_DECERR  2'h3

`endif

/* File: design/timer0_pkg.sv */
// types shared by the timer: bus carriers and the module state record
package timer0_pkg;

   // bus requests from the master
   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } axi_in_t;

   // bus answers to the master
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } axi_out_t;

   // complete state of the timer
   typedef struct packed {
      logic [7:0] count;
      logic [7:0] cmp_a;
      logic [7:0] cmp_b;
      logic [7:0] ctrl_a;
      logic [7:0] ctrl_b;
      logic [2:0] flags;
      logic [2:0] mask;
      logic       power_off;
      logic       dir_down;
      logic       block;
      logic [9:0] presc;
      logic       ext_s1;
      logic       ext_s2;
      logic       ext_prev;
      logic       wave_a;
      logic       wave_b;
      logic       aw_got;
      logic [7:0] awaddr;
      logic       w_got;
      logic [7:0] wdata;
      logic       wlane0;
      logic       bvalid;
      logic [1:0] bresp;
      logic       rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
   } state_t;

endpackage

/* File: design/timer0_counter_unit.sv */
// 8-bit timer/counter with two compare units behind an AXI4-Lite slave
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "timer0_defs.svh"

module timer0_counter_unit
   import timer0_pkg::*;
(
   input  wire logic     aclk,
   input  wire logic     aresetn,
   input  wire axi_in_t  axi_in,
   output axi_out_t      axi_out,
   input  wire logic     ext_count_pin,
   input  wire logic [2:0] irq_ack,
   output logic [2:0]    irq,
   output logic          wave_out_a,
   output logic          wave_out_b,
   output logic          at_top,
   output logic          at_bottom
);

   state_t     s;
   state_t     next_s;
   logic       tick;
   logic [2:0] mode;
   logic [7:0] top_value;
   logic       wr_fire;
   logic       rd_fire;
   logic       wr_count;
   logic       match_a;
   logic       match_b;

   // one step up or down
   function automatic logic [7:0] step(input logic [7:0] v, input logic down);
      step = down ? v - `T0_ONE8 : v + `T0_ONE8;
   endfunction

   // prescaler tap test for one divisor
   function automatic logic ps_tap(input logic [9:0] ps, input logic [9:0] m);
      ps_tap = (ps & m) == m;
   endfunction

   // output action for one compare unit on one tick
   function automatic logic wave_step(input logic cur, input logic [1:0] com,
                                      input logic [2:0] md, input logic hit,
                                      input logic wrap, input logic down);
      logic pwm_fast;
      logic pwm_pc;
      pwm_fast = (md == `T0_WGM_FAST_MAX) || (md == `T0_WGM_FAST_CMPA);
      pwm_pc = (md == `T0_WGM_PC_MAX) || (md == `T0_WGM_PC_CMPA);
      wave_step = cur;
      if (pwm_fast)
      begin
         if (hit && com == `T0_COM_CLEAR) wave_step = 1'b0;
         else if (hit && com == `T0_COM_SET) wave_step = 1'b1;
         else if (wrap && com == `T0_COM_CLEAR) wave_step = 1'b1;
         else if (wrap && com == `T0_COM_SET) wave_step = 1'b0;
      end
      else if (pwm_pc)
      begin
         if (hit && com == `T0_COM_CLEAR) wave_step = down;
         else if (hit && com == `T0_COM_SET) wave_step = !down;
      end
      else if (hit)
      begin
         if (com == `T0_COM_TOGGLE) wave_step = !cur;
         else if (com == `T0_COM_CLEAR) wave_step = 1'b0;
         else if (com == `T0_COM_SET) wave_step = 1'b1;
      end
   endfunction

   // mode, top and extreme indications
   assign mode = {s.ctrl_b[`T0_CB_WGM_HI], s.ctrl_a[`T0_CA_WGM_LO]};
   assign top_value = (mode == `T0_WGM_CTC || mode == `T0_WGM_PC_CMPA ||
                       mode == `T0_WGM_FAST_CMPA) ? s.cmp_a : `T0_MAX;
   assign at_top = (s.count == top_value);
   assign at_bottom = (s.count == `T0_BOTTOM);

   // comparators run every cycle; flags sample them on the tick
   assign match_a = (s.count == s.cmp_a);
   assign match_b = (s.count == s.cmp_b);

   // tick select; the pin is read only after its second sync stage
   always_comb
   begin
      tick = 1'b0;
      unique case (s.ctrl_b[`T0_CB_CS])
         `T0_CS_STOP:      tick = 1'b0;
         `T0_CS_DIV1:      tick = 1'b1;
         `T0_CS_DIV8:      tick = ps_tap(s.presc, `T0_PS_M8);
         `T0_CS_DIV64:     tick = ps_tap(s.presc, `T0_PS_M64);
         `T0_CS_DIV256:    tick = ps_tap(s.presc, `T0_PS_M256);
         `T0_CS_DIV1024:   tick = ps_tap(s.presc, `T0_PS_M1024);
         `T0_CS_EXT_FALL:  tick = s.ext_prev && !s.ext_s2;
         `T0_CS_EXT_RISE:  tick = !s.ext_prev && s.ext_s2;
      endcase
      if (s.power_off)
         tick = 1'b0;
   end

   // bus handshakes: one write and one read at a time
   assign axi_out.awready = !s.aw_got && !s.bvalid;
   assign axi_out.wready = !s.w_got && !s.bvalid;
   assign axi_out.bvalid = s.bvalid;
   assign axi_out.bresp = s.bresp;
   assign axi_out.arready = !s.rvalid;
   assign axi_out.rvalid = s.rvalid;
   assign axi_out.rdata = {24'h00_0000, s.rdata};
   assign axi_out.rresp = s.rresp;
   assign wr_fire = s.aw_got && s.w_got && !s.bvalid;
   assign rd_fire = axi_in.arvalid && !s.rvalid;
   assign wr_count = wr_fire && s.wlane0 && s.awaddr == `T0_OFS_COUNT;

   // outputs straight from the state
   assign irq = s.flags & s.mask;
   assign wave_out_a = s.wave_a;
   assign wave_out_b = s.wave_b;

   // next-state logic
   always_comb
   begin
      logic [2:0] set_f;
      logic [2:0] clr_f;
      logic       wrap;
      logic       hit_a;
      logic       hit_b;
      logic       force_a;
      logic       force_b;
      logic       pwm;
      set_f = 3'h0;
      clr_f = irq_ack;
      wrap = 1'b0;
      hit_a = 1'b0;
      hit_b = 1'b0;
      force_a = 1'b0;
      force_b = 1'b0;
      pwm = !(mode == `T0_WGM_NORMAL || mode == `T0_WGM_CTC);
      next_s = s;
      next_s.presc = s.power_off ? s.presc : s.presc + 10'h001;
      next_s.ext_s1 = ext_count_pin;
      next_s.ext_s2 = s.ext_s1;
      next_s.ext_prev = s.ext_s2;

      // counter on the tick
      if (tick)
      begin
         next_s.block = 1'b0;
         hit_a = match_a && !s.block;
         hit_b = match_b && !s.block;
         set_f[`T0_BIT_MATCH_A] = hit_a;
         set_f[`T0_BIT_MATCH_B] = hit_b;
         unique case (mode)
            `T0_WGM_NORMAL:
            begin
               next_s.count = step(s.count, 1'b0);
               wrap = (s.count == `T0_MAX);
            end
            `T0_WGM_CTC:
            begin
               next_s.count = match_a ? `T0_ZERO8 : step(s.count, 1'b0);
               wrap = (s.count == `T0_MAX);
            end
            `T0_WGM_FAST_MAX, `T0_WGM_FAST_CMPA:
            begin
               next_s.count = at_top ? `T0_ZERO8 : step(s.count, 1'b0);
               wrap = at_top;
            end
            `T0_WGM_PC_MAX, `T0_WGM_PC_CMPA:
            begin
               if (!s.dir_down && at_top)
               begin
                  next_s.dir_down = 1'b1;
                  next_s.count = step(s.count, 1'b1);
               end
               else if (s.dir_down && at_bottom)
               begin
                  next_s.dir_down = 1'b0;
                  next_s.count = step(s.count, 1'b0);
                  wrap = 1'b1;
               end
               else
                  next_s.count = step(s.count, s.dir_down);
            end
            default:
               next_s.count = step(s.count, 1'b0);
         endcase
         set_f[`T0_BIT_OVF] = wrap;
         if (!pwm)
            next_s.dir_down = 1'b0;
      end

      // register writes; a count write beats the tick
      if (wr_fire)
      begin
         next_s.bvalid = 1'b1;
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bresp = `T0_RESP_OKAY;
         if (s.wlane0)
         begin
            unique case (s.awaddr)
               `T0_OFS_COUNT:
               begin
                  next_s.count = s.wdata;
                  next_s.block = 1'b1;
               end
               `T0_OFS_CMP_A:  next_s.cmp_a = s.wdata;
               `T0_OFS_CMP_B:  next_s.cmp_b = s.wdata;
               `T0_OFS_CTRL_A: next_s.ctrl_a = s.wdata;
               `T0_OFS_CTRL_B:
               begin
                  next_s.ctrl_b = s.wdata & `T0_CB_STORED;
                  force_a = s.wdata[`T0_CB_FOC_A] && !pwm;
                  force_b = s.wdata[`T0_CB_FOC_B] && !pwm;
               end
               `T0_OFS_FLAG:   clr_f = clr_f | s.wdata[2:0];
               `T0_OFS_MASK:   next_s.mask = s.wdata[2:0];
               `T0_OFS_POWER:  next_s.power_off = s.wdata[0];
               default:        next_s.bresp = `T0_RESP_DECERR;
            endcase
         end
      end
      else
      begin
         if (axi_in.awvalid && axi_out.awready)
         begin
            next_s.aw_got = 1'b1;
            next_s.awaddr = axi_in.awaddr;
         end
         if (axi_in.wvalid && axi_out.wready)
         begin
            next_s.w_got = 1'b1;
            next_s.wdata = axi_in.wdata[7:0];
            next_s.wlane0 = axi_in.wstrb[0];
         end
      end
      if (s.bvalid && axi_in.bready)
         next_s.bvalid = 1'b0;

      // set wins over clear
      next_s.flags = (s.flags & ~clr_f) | set_f;

      // waveform outputs
      next_s.wave_a = wave_step(s.wave_a, s.ctrl_a[`T0_CA_COM_A], mode,
                                hit_a || force_a, wrap, s.dir_down);
      next_s.wave_b = wave_step(s.wave_b, s.ctrl_a[`T0_CA_COM_B], mode,
                                hit_b || force_b, wrap, s.dir_down);

      // register reads
      if (rd_fire)
      begin
         next_s.rvalid = 1'b1;
         next_s.rresp = `T0_RESP_OKAY;
         unique case (axi_in.araddr)
            `T0_OFS_COUNT:  next_s.rdata = s.count;
            `T0_OFS_CMP_A:  next_s.rdata = s.cmp_a;
            `T0_OFS_CMP_B:  next_s.rdata = s.cmp_b;
            `T0_OFS_CTRL_A: next_s.rdata = s.ctrl_a;
            `T0_OFS_CTRL_B: next_s.rdata = s.ctrl_b;
            `T0_OFS_FLAG:   next_s.rdata = {5'h00, s.flags};
            `T0_OFS_MASK:   next_s.rdata = {5'h00, s.mask};
            `T0_OFS_POWER:  next_s.rdata = {7'h00, s.power_off};
            default:
            begin
               next_s.rdata = `T0_ZERO8;
               next_s.rresp = `T0_RESP_DECERR;
            end
         endcase
      end
      else if (s.rvalid && axi_in.rready)
         next_s.rvalid = 1'b0;
   end

   // state register; all zero leaves the timer stopped
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s <= '0;
      else
         s <= next_s;
   end

   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_stop_holds;
      s.ctrl_b[`T0_CB_CS] == `T0_CS_STOP && !wr_count |=> $stable(s.count);
   endproperty
   a_stop_holds: assert property (p_stop_holds)
      else $error("count moved while stopped");

   // tick is dead in the power-off cycle itself; count and prescaler hold after it
   property p_power_off;
      s.power_off && !wr_count |-> !tick ##1 ($stable(s.count) && $stable(s.presc));
   endproperty
   a_power_off: assert property (p_power_off)
      else $error("count moved while powered off");

   property p_write_priority;
      wr_count |=> s.count == $past(s.wdata) && s.block;
   endproperty
   a_write_priority: assert property (p_write_priority)
      else $error("count write lost");

   property p_normal_wrap;
      tick && mode == `T0_WGM_NORMAL && s.count == `T0_MAX && !wr_count
         |=> s.count == `T0_ZERO8 && s.flags[`T0_BIT_OVF];
   endproperty
   a_normal_wrap: assert property (p_normal_wrap)
      else $error("normal mode wrap or overflow wrong");

   property p_ctc_clear;
      tick && mode == `T0_WGM_CTC && match_a && !wr_count |=> at_bottom;
   endproperty
   a_ctc_clear: assert property (p_ctc_clear)
      else $error("no clear on compare A");

   property p_step_one;
      tick && mode == `T0_WGM_NORMAL && !wr_count
         |=> s.count == 8'($past(s.count) + 8'h01);
   endproperty
   a_step_one: assert property (p_step_one)
      else $error("step not one");

   // the flag may only drop again through a service acknowledge or a bus write
   property p_match_flag;
      tick && match_b && !s.block |=> s.flags[`T0_BIT_MATCH_B]
         ##1 (s.flags[`T0_BIT_MATCH_B] || $past(irq_ack[`T0_BIT_MATCH_B]) || $past(wr_fire));
   endproperty
   a_match_flag: assert property (p_match_flag)
      else $error("compare B flag not set or not held");

   property p_flag_needs_tick;
      !tick |=> (s.flags & ~$past(s.flags)) == 3'h0;
   endproperty
   a_flag_needs_tick: assert property (p_flag_needs_tick)
      else $error("flag set without tick");

   property p_blocked_match;
      wr_count ##1 (tick && match_a && !wr_count && !$past(s.flags[1]))
         |=> !$rose(s.flags[`T0_BIT_MATCH_A]);
   endproperty
   a_blocked_match: assert property (p_blocked_match)
      else $error("match not blocked after count write");

endmodule

/* File: tb/timer0_counter_unit_tb_top.sv */
// self-checking bench for the 8-bit timer behind its AXI4-Lite slave
`timescale 1ns/1ns
`include "timer0_defs.svh"

module timer0_counter_unit_tb_top
   import timer0_pkg::*;
;
   logic        aclk;
   logic        aresetn;
   axi_in_t     axi_in;
   axi_out_t    axi_out;
   logic        ext_count_pin;
   logic [2:0]  irq_ack;
   logic [2:0]  irq;
   logic        wave_out_a;
   logic        wave_out_b;
   logic        at_top;
   logic        at_bottom;
   int          err_count;
   int          comparisons;
   int          i;
   int          div_tab [1:5];
   logic [31:0] rv;
   logic [1:0]  rr;
   logic        prev_top;

   timer0_counter_unit i_dut (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .axi_in        (axi_in),
      .axi_out       (axi_out),
      .ext_count_pin (ext_count_pin),
      .irq_ack       (irq_ack),
      .irq           (irq),
      .wave_out_a    (wave_out_a),
      .wave_out_b    (wave_out_b),
      .at_top        (at_top),
      .at_bottom     (at_bottom)
   );

   // 20 MHz clock
   always #25 aclk = ~aclk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // one write; address and data released separately as each is taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_d;
      logic w_d;
      logic done;
      aw_d = 1'b0;
      w_d = 1'b0;
      done = 1'b0;
      @(posedge aclk);
      axi_in.awvalid <= 1'b1;
      axi_in.awaddr <= a;
      axi_in.wvalid <= 1'b1;
      axi_in.wdata <= d;
      axi_in.wstrb <= 4'hF;
      axi_in.bready <= 1'b1;
      // no cycle limit of its own; the watchdog ends a hang
      while (!done)
      begin
         @(posedge aclk);
         if (!aw_d && axi_out.awready === 1'b1)
         begin
            aw_d = 1'b1;
            axi_in.awvalid <= 1'b0;
         end
         if (!w_d && axi_out.wready === 1'b1)
         begin
            w_d = 1'b1;
            axi_in.wvalid <= 1'b0;
         end
         if (axi_out.bvalid === 1'b1)
         begin
            done = 1'b1;
            axi_in.bready <= 1'b0;
            check({30'h0, axi_out.bresp}, {30'h0, er});
         end
      end
      check({30'h0, aw_d, w_d}, 32'h0000_0003);
   endtask

   // one read; rready held until the answer is sampled
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar_d;
      logic done;
      ar_d = 1'b0;
      done = 1'b0;
      d = 32'h0000_0000;
      r = 2'h0;
      @(posedge aclk);
      axi_in.arvalid <= 1'b1;
      axi_in.araddr <= a;
      axi_in.rready <= 1'b1;
      while (!done)
      begin
         @(posedge aclk);
         if (!ar_d && axi_out.arready === 1'b1)
         begin
            ar_d = 1'b1;
            axi_in.arvalid <= 1'b0;
         end
         if (axi_out.rvalid === 1'b1)
         begin
            done = 1'b1;
            d = axi_out.rdata;
            r = axi_out.rresp;
            axi_in.rready <= 1'b0;
         end
      end
      check({31'h0, ar_d}, 32'h0000_0001);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      check(d, exp);
      check({30'h0, r}, {30'h0, `T0_RESP_OKAY});
   endtask

   // pin pulses spaced well beyond the three-edge synchroniser delay
   task automatic pulse(input int n);
      repeat (n)
      begin
         @(posedge aclk);
         ext_count_pin <= 1'b1;
         repeat (6) @(posedge aclk);
         ext_count_pin <= 1'b0;
         repeat (6) @(posedge aclk);
      end
   endtask

   // watchdog: the /1024 run dominates, about 45k cycles in all
   initial
   begin
      repeat (60000) @(posedge aclk);
      err_count++;
      end_sim();
   end

   initial
   begin
      aclk = 1'b0;
      aresetn = 1'b0;
      axi_in = '0;
      ext_count_pin = 1'b0;
      irq_ack = 3'h0;
      err_count = 0;
      comparisons = 0;
      div_tab = '{1, 8, 64, 256, 1024};
      repeat (8) @(posedge aclk);
      check({30'h0, at_bottom, at_top}, 32'h0000_0002);
      aresetn <= 1'b1;
      // every register starts at zero
      for (i = 0; i < 8; i++)
         rd_chk(8'(4 * i), 32'h0000_0000);
      check({29'h0, irq}, 32'h0000_0000);
      // unmapped place answers with a decode error
      rd(8'h20, rv, rr);
      check({30'h0, rr}, {30'h0, `T0_RESP_DECERR});
      check(rv, 32'h0000_0000);
      wr(8'h20, 32'h0000_00FF, `T0_RESP_DECERR);
      // only the low byte is kept
      wr(`T0_OFS_CMP_A, 32'h0000_01A5, `T0_RESP_OKAY);
      rd_chk(`T0_OFS_CMP_A, 32'h0000_00A5);
      wr(`T0_OFS_CMP_B, 32'h0000_035A, `T0_RESP_OKAY);
      rd_chk(`T0_OFS_CMP_B, 32'h0000_005A);
      wr(`T0_OFS_MASK, 32'h0000_0007, `T0_RESP_OKAY);
      rd_chk(`T0_OFS_MASK, 32'h0000_0007);
      // forced matches: A toggles, B sets, no flag raised
      wr(`T0_OFS_CTRL_A, 32'h0000_0070, `T0_RESP_OKAY);
      rd_chk(`T0_OFS_CTRL_A, 32'h0000_0070);
      wr(`T0_OFS_CTRL_B, 32'h0000_00C0, `T0_RESP_OKAY);
      rd_chk(`T0_OFS_CTRL_B, 32'h0000_0000);
      check({30'h0, wave_out_a, wave_out_b}, 32'h0000_0003);
      wr(`T0_OFS_CTRL_B, 32'h0000_00C0, `T0_RESP_OKAY);
      repeat (2) @(posedge aclk);
      check({30'h0, wave_out_a, wave_out_b}, 32'h0000_0001);
      rd_chk(`T0_OFS_FLAG, 32'h0000_0000);
      // stopped: pin edges and time leave the count alone
      wr(`T0_OFS_CTRL_A, 32'h0000_0000, `T0_RESP_OKAY);
      wr(`T0_OFS_COUNT, 32'h0000_0010, `T0_RESP_OKAY);
      pulse(3);
      rd_chk(`T0_OFS_COUNT, 32'h0000_0010);
      // powered off the selected clock does nothing
      wr(`T0_OFS_POWER, 32'h0000_0001, `T0_RESP_OKAY);
      wr(`T0_OFS_CTRL_B, {29'h0, `T0_CS_DIV1}, `T0_RESP_OKAY);
      repeat (20) @(posedge aclk);
      rd_chk(`T0_OFS_COUNT, 32'h0000_0010);
      wr(`T0_OFS_POWER, 32'h0000_0000, `T0_RESP_OKAY);
      // running write near the top, then watch the wrap
      wr(`T0_OFS_COUNT, 32'h0000_00F0, `T0_RESP_OKAY);
      prev_top = 1'b0;
      for (i = 0; i < 40 && irq[0] !== 1'b1; i++)
      begin
         prev_top = at_top;
         @(posedge aclk);
      end
      check({31'h0, irq[0]}, 32'h0000_0001);
      check({31'h0, at_bottom}, 32'h0000_0001);
      check({31'h0, prev_top}, 32'h0000_0001);
      wr(`T0_OFS_CTRL_B, 32'h0000_0000, `T0_RESP_OKAY);
      rd_chk(`T0_OFS_FLAG, 32'h0000_0001);
      wr(`T0_OFS_MASK, 32'h0000_0006, `T0_RESP_OKAY);
      check({29'h0, irq}, 32'h0000_0000);
      wr(`T0_OFS_FLAG, 32'h0000_0001, `T0_RESP_OKAY);
      rd_chk(`T0_OFS_FLAG, 32'h0000_0000);
      // clear on compare A: count stays at or below 5
      wr(`T0_OFS_CTRL_A, {29'h0, `T0_WGM_CTC}, `T0_RESP_OKAY);
      wr(`T0_OFS_CMP_A, 32'h0000_0005, `T0_RESP_OKAY);
      wr(`T0_OFS_COUNT, 32'h0000_0000, `T0_RESP_OKAY);
      wr(`T0_OFS_CTRL_B, {29'h0, `T0_CS_DIV1}, `T0_RESP_OKAY);
      repeat (30) @(posedge aclk);
      wr(`T0_OFS_CTRL_B, 32'h0000_0000, `T0_RESP_OKAY);
      rd(`T0_OFS_COUNT, rv, rr);
      check({31'h0, rv <= 32'h0000_0005}, 32'h0000_0001);
      rd_chk(`T0_OFS_FLAG, 32'h0000_0002);
      check({29'h0, irq}, 32'h0000_0002);
      // service acknowledge clears the flag
      @(posedge aclk);
      irq_ack <= 3'h2;
      @(posedge aclk);
      irq_ack <= 3'h0;
      rd_chk(`T0_OFS_FLAG, 32'h0000_0000);
      // count written equal to compare B: that match is lost
      wr(`T0_OFS_CTRL_A, 32'h0000_0000, `T0_RESP_OKAY);
      wr(`T0_OFS_CMP_B, 32'h0000_0040, `T0_RESP_OKAY);
      wr(`T0_OFS_COUNT, 32'h0000_0040, `T0_RESP_OKAY);
      wr(`T0_OFS_CTRL_B, {29'h0, `T0_CS_DIV1}, `T0_RESP_OKAY);
      repeat (4) @(posedge aclk);
      wr(`T0_OFS_CTRL_B, 32'h0000_0000, `T0_RESP_OKAY);
      rd_chk(`T0_OFS_FLAG, 32'h0000_0000);
      // running write equal to compare A is blocked; compare B matches later
      wr(`T0_OFS_CTRL_B, {29'h0, `T0_CS_DIV1}, `T0_RESP_OKAY);
      wr(`T0_OFS_COUNT, 32'h0000_0005, `T0_RESP_OKAY);
      wr(`T0_OFS_COUNT, 32'h0000_003C, `T0_RESP_OKAY);
      repeat (6) @(posedge aclk);
      wr(`T0_OFS_CTRL_B, 32'h0000_0000, `T0_RESP_OKAY);
      rd_chk(`T0_OFS_FLAG, 32'h0000_0004);
      wr(`T0_OFS_FLAG, 32'h0000_0007, `T0_RESP_OKAY);
      // phase correct, top at compare A: up, down, overflow at bottom
      wr(`T0_OFS_COUNT, 32'h0000_0000, `T0_RESP_OKAY);
      wr(`T0_OFS_CTRL_A, 32'h0000_0001, `T0_RESP_OKAY);
      wr(`T0_OFS_CTRL_B, 32'h0000_0009, `T0_RESP_OKAY);
      repeat (20) @(posedge aclk);
      wr(`T0_OFS_CTRL_B, 32'h0000_0000, `T0_RESP_OKAY);
      rd(`T0_OFS_COUNT, rv, rr);
      check({31'h0, rv <= 32'h0000_0005}, 32'h0000_0001);
      rd_chk(`T0_OFS_FLAG, 32'h0000_0003);
      wr(`T0_OFS_FLAG, 32'h0000_0003, `T0_RESP_OKAY);
      wr(`T0_OFS_CTRL_A, 32'h0000_0000, `T0_RESP_OKAY);
      // top follows the mode: 0xFF in mode 0, compare A in mode 7
      wr(`T0_OFS_CMP_A, 32'h0000_0020, `T0_RESP_OKAY);
      wr(`T0_OFS_COUNT, 32'h0000_0020, `T0_RESP_OKAY);
      check({31'h0, at_top}, 32'h0000_0000);
      wr(`T0_OFS_CTRL_A, 32'h0000_0003, `T0_RESP_OKAY);
      wr(`T0_OFS_CTRL_B, 32'h0000_0008, `T0_RESP_OKAY);
      check({31'h0, at_top}, 32'h0000_0001);
      wr(`T0_OFS_CTRL_A, 32'h0000_0000, `T0_RESP_OKAY);
      // external pin: rising then falling edges
      wr(`T0_OFS_COUNT, 32'h0000_0000, `T0_RESP_OKAY);
      wr(`T0_OFS_CTRL_B, {29'h0, `T0_CS_EXT_RISE}, `T0_RESP_OKAY);
      pulse(4);
      wr(`T0_OFS_CTRL_B, {29'h0, `T0_CS_EXT_FALL}, `T0_RESP_OKAY);
      pulse(3);
      wr(`T0_OFS_CTRL_B, 32'h0000_0000, `T0_RESP_OKAY);
      rd_chk(`T0_OFS_COUNT, 32'h0000_0007);
      // each internal rate: 32 ticks, slack for bus latency and phase
      for (i = 1; i <= 5; i++)
      begin
         wr(`T0_OFS_COUNT, 32'h0000_0000, `T0_RESP_OKAY);
         wr(`T0_OFS_CTRL_B, 32'(i), `T0_RESP_OKAY);
         repeat (32 * div_tab[i]) @(posedge aclk);
         wr(`T0_OFS_CTRL_B, 32'h0000_0000, `T0_RESP_OKAY);
         rd(`T0_OFS_COUNT, rv, rr);
         check({31'h0, rv >= 32'd30 && rv <= 32'd36}, 32'h0000_0001);
      end
      end_sim();
   end
endmodule
